// ===== design/adaptive_slimming_serial_logic.sv
// Slimming field decoder, nibble store and three-line processor link
`timescale 1ns/1ps
`include "slim_link_defines.svh"

module adaptive_slimming_serial_logic
  import slim_link_pkg::*;
#(
  parameter int HSEL_W = 4
) (
  input  wire logic              mclk_in,
  input  wire logic              resetn_in,
  input  wire logic              disk_bit_in,
  input  wire logic              disk_strobe_in,
  input  wire logic [HSEL_W-1:0] head_sel_in,
  input  wire logic              ser_clk_in,
  input  wire logic              ser_data_in,
  output logic                   ser_data_out,
  output logic                   ser_data_oe_out,
  input  wire logic              ser_ctrl_in,
  output logic                   ser_ctrl_out,
  output logic                   ser_ctrl_oe_out,
  output logic [3:0]             slim_out,
  output logic [3:0]             cfg_out,
  output logic [3:0]             max_head_out,
  output logic [3:0]             diag_out
);

  localparam int HEADS = 1 << HSEL_W;

  // Status pair index is a nibble, so at most eight slimming pairs
  if (HSEL_W < 2 || HSEL_W > 4) begin : g_bad_hsel
    $error("HSEL_W must be 2 to 4");
  end
  if (`FRAME_BYTES * 8 != `CELL_BITS * `BYTE_BITS) begin : g_bad_frame
    $error("Frame length must hold one byte of cells");
  end

  // ****************************************************************
  // Link domain: shift in on rising, shift out on falling edges
  // ****************************************************************
  logic [7:0] rx_q, rx_d, tx_q;
  logic [2:0] tx_idx_q, tx_idx_d;
  logic       tx_bit_q, tx_bit_d, tx_drv_q, tx_drv_d, pend_q;
  always_comb begin
    rx_d = {ser_data_in, rx_q[7:1]};
  end
  always_ff @(posedge ser_clk_in) begin
    rx_q <= rx_d;
  end

  // tx_q and pend_q are held still for the whole frame, so the link
  // clock may read them without a synchroniser
  always_comb begin
    tx_idx_d = tx_idx_q;
    tx_bit_d = tx_bit_q;
    tx_drv_d = tx_drv_q;
    if (pend_q) begin
      tx_bit_d = tx_q[tx_idx_q];
      tx_idx_d = tx_idx_q + 3'h1;
      tx_drv_d = 1'b1;
    end
  end

  // The link clock stops outside frames; the frame's own control level
  // ends the transfer and releases the data line
  always_ff @(negedge ser_clk_in or posedge ser_ctrl_in) begin
    if (ser_ctrl_in) begin
      tx_idx_q <= 3'h0;
      tx_bit_q <= 1'b0;
      tx_drv_q <= 1'b0;
    end else begin
      tx_idx_q <= tx_idx_d;
      tx_bit_q <= tx_bit_d;
      tx_drv_q <= tx_drv_d;
    end
  end

  assign ser_data_out    = tx_bit_q;
  assign ser_data_oe_out = tx_drv_q & pend_q;
  assign ser_ctrl_out    = 1'b0;

  // ****************************************************************
  // Pin synchronisers into the main clock
  // ****************************************************************
  logic [1:0] clk_sy_q, ctrl_sy_q, data_sy_q;
  logic       ctrl_prev_q, clk_s, ctrl_s, abort, ctrl_rise;
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      clk_sy_q    <= 2'h3;
      ctrl_sy_q   <= 2'h3;
      data_sy_q   <= 2'h3;
      ctrl_prev_q <= 1'b1;
    end else begin
      clk_sy_q    <= {clk_sy_q[0], ser_clk_in};
      ctrl_sy_q   <= {ctrl_sy_q[0], ser_ctrl_in};
      data_sy_q   <= {data_sy_q[0], ser_data_in};
      ctrl_prev_q <= ctrl_sy_q[1];
    end
  end

  assign clk_s     = clk_sy_q[1];
  assign ctrl_s    = ctrl_sy_q[1];
  assign abort     = ctrl_s & ~clk_s & ~data_sy_q[1];
  assign ctrl_rise = ctrl_s & ~ctrl_prev_q;

  // ****************************************************************
  // Stored nibbles
  // ****************************************************************
  logic [3:0]        slim_q [HEADS];
  logic [HSEL_W-1:0] ptr_q, ptr_d;
  nibble_t           cfg_q, cfg_d, maxh_q, maxh_d, diag_q, diag_d;
  logic              slim_we, cmd_take;
  logic [3:0]        cmd_op, cmd_arg;
  assign cmd_op  = rx_q[7:4];
  assign cmd_arg = rx_q[3:0];
  for (genvar i = 0; i < HEADS; i++) begin : g_slim
    logic [3:0] slim_d;
    always_comb begin
      slim_d = slim_q[i];
      if (slim_we && ptr_q == HSEL_W'(i)) begin
        slim_d = cmd_arg;
      end
    end
    always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
        slim_q[i] <= `NIBBLE_RESET;
      end else begin
        slim_q[i] <= slim_d;
      end
    end
  end

  assign slim_we = cmd_take && cmd_op == CMD_SLIM;

  always_comb begin
    ptr_d  = ptr_q;
    cfg_d  = cfg_q;
    maxh_d = maxh_q;
    diag_d = diag_q;
    if (cmd_take) begin
      unique case (cmd_op)
        CMD_HEAD_PTR: ptr_d  = cmd_arg[HSEL_W-1:0];
        CMD_SLIM:     ptr_d  = ptr_q + 1'b1;
        CMD_CFG:      cfg_d  = cmd_arg;
        CMD_MAXHEAD:  maxh_d = cmd_arg;
        CMD_DIAG:     diag_d = cmd_arg;
        default:      ptr_d  = ptr_q;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      ptr_q  <= '0;
      cfg_q  <= `NIBBLE_RESET;
      maxh_q <= `NIBBLE_RESET;
      diag_q <= `NIBBLE_RESET;
    end else begin
      ptr_q  <= ptr_d;
      cfg_q  <= cfg_d;
      maxh_q <= maxh_d;
      diag_q <= diag_d;
    end
  end

  assign slim_out     = slim_q[head_sel_in];
  assign cfg_out      = cfg_q;
  assign max_head_out = maxh_q;
  assign diag_out     = diag_q;

  // ****************************************************************
  // Field decoder and byte handshake
  // ****************************************************************
  dec_state_e        dec_q, dec_d;
  logic [7:0]        zrun_q, zrun_d, sh_q, sh_d, tx_d, stat_byte;
  logic [4:0]        cell_q, cell_d;
  logic [5:0]        ones_q, ones_d, ones_n;
  logic [2:0]        lbit_q, lbit_d;
  logic              pend_d, xfer_q, xfer_d, stat_q, stat_d, ctrl_oe_q, ctrl_oe_d, byte_done;
  logic [HSEL_W-1:0] pair;
  assign pair   = {cmd_arg[HSEL_W-2:0], 1'b0};
  assign ones_n = ones_q + {5'h00, disk_bit_in};
  always_comb begin
    if (cmd_arg < 4'((HEADS / 2))) begin
      stat_byte = {slim_q[pair + 1'b1], slim_q[pair]};
    end else if (cmd_arg == 4'((HEADS / 2))) begin
      stat_byte = {maxh_q, cfg_q};
    end else begin
      stat_byte = {4'h0, diag_q};
    end
  end

  always_comb begin
    dec_d     = dec_q;
    zrun_d    = zrun_q;
    sh_d      = sh_q;
    cell_d    = cell_q;
    ones_d    = ones_q;
    lbit_d    = lbit_q;
    tx_d      = tx_q;
    pend_d    = pend_q;
    xfer_d    = xfer_q;
    stat_d    = stat_q;
    cmd_take  = 1'b0;
    byte_done = 1'b0;
    if (pend_q && !clk_s && !ctrl_s) begin
      xfer_d = 1'b1;
    end
    if (ctrl_rise) begin
      if (xfer_q) begin
        pend_d = 1'b0;
        xfer_d = 1'b0;
        stat_d = 1'b0;
      end else if (!abort) begin
        // A half-shifted byte left by an abort is no command
        cmd_take = 1'b1;
      end
    end
    if (cmd_take && cmd_op == CMD_READOUT) begin
      dec_d  = DEC_HUNT;
      zrun_d = 8'h00;
    end
    if (cmd_take && cmd_op == CMD_STATUS && !pend_d) begin
      tx_d   = stat_byte;
      pend_d = 1'b1;
      stat_d = 1'b1;
    end
    if (disk_strobe_in) begin
      unique case (dec_q)
        DEC_IDLE: dec_d = DEC_IDLE;
        DEC_HUNT: begin
          if (!disk_bit_in) begin
            zrun_d = (zrun_q == 8'hFF) ? zrun_q : zrun_q + 8'h01;
          end else if (zrun_q >= 8'(`SYNC_ZERO_BITS)) begin
            dec_d  = DEC_SYNC;
            sh_d   = {disk_bit_in, 7'h00};
            lbit_d = 3'h1;
          end else begin
            zrun_d = 8'h00;
          end
        end
        DEC_SYNC: begin
          sh_d   = {disk_bit_in, sh_q[7:1]};
          lbit_d = lbit_q + 3'h1;
          if (lbit_q == 3'h7) begin
            zrun_d = 8'h00;
            lbit_d = 3'h0;
            cell_d = 5'h00;
            ones_d = 6'h00;
            dec_d  = (sh_d == `SYNC_BYTE) ? DEC_DATA : DEC_HUNT;
          end
        end
        DEC_DATA: begin
          cell_d = cell_q + 5'h01;
          ones_d = ones_n;
          if (cell_q == 5'(`CELL_BITS - 1)) begin
            ones_d = 6'h00;
            sh_d   = {(ones_n > 6'(`CELL_THRESHOLD)), sh_q[7:1]};
            lbit_d = lbit_q + 3'h1;
            // Eight cells fill one frame, so bytes follow frame by frame
            byte_done = (lbit_q == 3'(`BYTE_BITS - 1));
          end
        end
        default: dec_d = DEC_IDLE;
      endcase
    end
    // A byte found while one waits is dropped; order on disk is kept
    if (byte_done && !pend_d) begin
      tx_d   = sh_d;
      pend_d = 1'b1;
    end
    if (abort) begin
      dec_d  = DEC_IDLE;
      pend_d = 1'b0;
      xfer_d = 1'b0;
      stat_d = 1'b0;
    end
    ctrl_oe_d = pend_d & ~xfer_d & ~abort;
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      dec_q     <= DEC_IDLE;
      zrun_q    <= 8'h00;
      sh_q      <= 8'h00;
      cell_q    <= 5'h00;
      ones_q    <= 6'h00;
      lbit_q    <= 3'h0;
      tx_q      <= 8'h00;
      pend_q    <= 1'b0;
      xfer_q    <= 1'b0;
      stat_q    <= 1'b0;
      ctrl_oe_q <= 1'b0;
    end else begin
      dec_q     <= dec_d;
      zrun_q    <= zrun_d;
      sh_q      <= sh_d;
      cell_q    <= cell_d;
      ones_q    <= ones_d;
      lbit_q    <= lbit_d;
      tx_q      <= tx_d;
      pend_q    <= pend_d;
      xfer_q    <= xfer_d;
      stat_q    <= stat_d;
      ctrl_oe_q <= ctrl_oe_d;
    end
  end

  assign ser_ctrl_oe_out = ctrl_oe_q;

endmodule

// ===== inc/slim_link_defines.svh
// Constants for the slimming decoder and its serial link
`ifndef SLIM_LINK_DEFINES_SVH
`define SLIM_LINK_DEFINES_SVH

// ****************************************************************
// Recorded field format
// ****************************************************************
`define SYNC_ZERO_BYTES 31
`define SYNC_ZERO_BITS  (`SYNC_ZERO_BYTES * 8)
`define SYNC_BYTE       8'hF7
`define FRAME_BYTES     32
`define CELL_BITS       32
`define CELL_ONE_BITS   24
`define CELL_THRESHOLD  12
`define BYTE_BITS       8

// ****************************************************************
// Reset values of the stored nibbles
// ****************************************************************
`define NIBBLE_RESET    4'h0

`endif

// ===== inc/slim_link_pkg.sv
// Types for the slimming decoder and its serial link
package slim_link_pkg;

  typedef enum logic [3:0] {
    DEC_IDLE = 4'b0001,
    DEC_HUNT = 4'b0010,
    DEC_SYNC = 4'b0100,
    DEC_DATA = 4'b1000
  } dec_state_e;

  typedef enum logic [3:0] {
    CMD_READOUT  = 4'h1,
    CMD_HEAD_PTR = 4'h2,
    CMD_SLIM     = 4'h3,
    CMD_CFG      = 4'h4,
    CMD_MAXHEAD  = 4'h5,
    CMD_DIAG     = 4'h6,
    CMD_STATUS   = 4'h7
  } cmd_e;

  typedef logic [3:0] nibble_t;

endpackage

// ===== verif/slim_link_asserts.sv
// Checker for link handshake, abort and nibble timing
`timescale 1ns/1ps
module slim_link_asserts
  import slim_link_pkg::*;
#(parameter int HSEL_W = 4) (
  input wire logic              mclk_in,
  input wire logic              resetn_in,
  input wire logic              disk_bit_in,
  input wire logic              disk_strobe_in,
  input wire logic [HSEL_W-1:0] head_sel_in,
  input wire logic              ser_clk_in,
  input wire logic              ser_data_in,
  input wire logic              ser_data_out,
  input wire logic              ser_data_oe_out,
  input wire logic              ser_ctrl_in,
  input wire logic              ser_ctrl_out,
  input wire logic              ser_ctrl_oe_out,
  input wire logic [3:0]        slim_out,
  input wire logic [3:0]        cfg_out,
  input wire logic [3:0]        max_head_out,
  input wire logic [3:0]        diag_out
);
  default clocking dcb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  // ****
  // Link properties
  // ****
  sequence s_abort;
    (ser_ctrl_in && !ser_clk_in && !ser_data_in) [*3];
  endsequence
  sequence s_ready_clk_high;
    (ser_ctrl_oe_out && ser_clk_in) [*3];
  endsequence
  // Reset checks must run while reset is low
  property p_rst_lines;
    disable iff (1'b0) !resetn_in |=> !ser_ctrl_oe_out && !ser_data_oe_out;
  endproperty
  property p_rst_nib;
    disable iff (1'b0) !resetn_in |=> {cfg_out, max_head_out, diag_out} == 12'h000;
  endproperty
  property p_ready_held;
    s_ready_clk_high |=> ser_ctrl_oe_out;
  endproperty
  property p_release;
    $fell(ser_clk_in) && ser_ctrl_oe_out |-> ##[1:5] !ser_ctrl_oe_out;
  endproperty
  property p_data_off;
    ser_ctrl_in |-> !ser_data_oe_out;
  endproperty
  property p_oe_rise;
    $rose(ser_data_oe_out) |-> !ser_clk_in && !ser_ctrl_in;
  endproperty
  property p_abort;
    s_abort |-> ##3 (!ser_ctrl_oe_out && !ser_data_oe_out) [*8];
  endproperty
  property p_cmd_wait;
    $rose(ser_ctrl_in) |-> $stable({cfg_out, max_head_out, diag_out}) [*2];
  endproperty
  a_rst_lines: assert property (p_rst_lines) else $error("lines driven in reset");
  a_rst_nib: assert property (p_rst_nib) else $error("nibbles not cleared");
  a_ready_held: assert property (p_ready_held) else $error("ready dropped early");
  a_release: assert property (p_release) else $error("control not released");
  a_data_off: assert property (p_data_off) else $error("data driven, control idle");
  a_oe_rise: assert property (p_oe_rise) else $error("data driven unasked");
  a_abort: assert property (p_abort) else $error("abort left lines driven");
  a_cmd_wait: assert property (p_cmd_wait) else $error("command taken early");
endmodule

// ===== verif/proc_port_model.sv
// Processor serial port model: clock, data and control pull-downs
`timescale 1ns/1ps
module proc_port_model (
  output logic      clk_out,
  output logic      data_low_out,
  output logic      ctrl_low_out,
  input  wire logic data_in,
  input  wire logic ctrl_in
);
  // ****
  // Port actions
  // ****
  initial begin
    clk_out = 1'b1;
    data_low_out = 1'b0;
    ctrl_low_out = 1'b0;
  end
  task automatic send_cmd(input logic [7:0] b);
    ctrl_low_out = 1'b1;
    #6;
    for (int i = 0; i < 8; i++) begin
      clk_out = 1'b0;
      data_low_out = ~b[i];
      #6 clk_out = 1'b1;
      #6;
    end
    data_low_out = 1'b0;
    ctrl_low_out = 1'b0;
    #40;
  endtask
  task automatic get_byte(output logic [7:0] b);
    wait (ctrl_in === 1'b0);
    #3 ctrl_low_out = 1'b1;
    #6;
    for (int i = 0; i < 8; i++) begin
      clk_out = 1'b0;
      #6 clk_out = 1'b1;
      b[i] = data_in;
      #6;
    end
    ctrl_low_out = 1'b0;
    #40;
  endtask
  task automatic abort();
    clk_out = 1'b0;
    data_low_out = 1'b1;
    #30;
    clk_out = 1'b1;
    data_low_out = 1'b0;
    #40;
  endtask
endmodule

// ===== verif/tb_top.sv
// Bench top: clock, wires, command, status, readout and abort tests
`timescale 1ns/1ps
`include "slim_link_defines.svh"
module tb_top;
  import slim_link_pkg::*;
  logic       mclk, rstn, dbit, dstb, pclk, pdl, pcl, sdo, sdoe, sco, scoe;
  logic [3:0] hsel, slim, cfg, maxh, diag;
  logic [7:0] got, prev;
  int         mismatches, samples_checked;
  logic [3:0] st_arg [5] = '{4'h0, 4'h1, 4'h3, 4'h8, 4'h9};
  logic [7:0] st_exp [5] = '{8'hA9, 8'hCB, 8'h07, 8'h3A, 8'h05};
  logic [7:0] rd_val [3] = '{8'h5A, 8'hFF, 8'hFF};
  int         rd_ones [3] = '{24, 13, 12};
  wire        sdata = !(pdl || (sdoe && !sdo));
  wire        sctrl = !(pcl || (scoe && !sco));
  adaptive_slimming_serial_logic #(.HSEL_W(4)) u_adaptive_slimming_serial_logic (
    .mclk_in(mclk), .resetn_in(rstn), .disk_bit_in(dbit), .disk_strobe_in(dstb),
    .head_sel_in(hsel), .ser_clk_in(pclk), .ser_data_in(sdata), .ser_data_out(sdo),
    .ser_data_oe_out(sdoe), .ser_ctrl_in(sctrl), .ser_ctrl_out(sco),
    .ser_ctrl_oe_out(scoe), .slim_out(slim), .cfg_out(cfg), .max_head_out(maxh),
    .diag_out(diag));
  proc_port_model u_proc_port_model (.clk_out(pclk), .data_low_out(pdl),
    .ctrl_low_out(pcl), .data_in(sdata), .ctrl_in(sctrl));
  // ****
  // Tasks
  // ****
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] op, input logic [3:0] arg);
    u_proc_port_model.send_cmd({op, arg});
    @(negedge mclk);
  endtask
  task automatic feed_bit(input logic b);
    @(negedge mclk);
    dbit = b;
    dstb = 1'b1;
    @(negedge mclk);
    dstb = 1'b0;
  endtask
  task automatic feed_sync();
    repeat (`SYNC_ZERO_BITS) feed_bit(1'b0);
    for (int i = 0; i < 8; i++) feed_bit(1'((`SYNC_BYTE) >> i));
  endtask
  task automatic feed_byte(input logic [7:0] b, input int ones);
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < `CELL_BITS; j++) feed_bit(b[i] && j < ones);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Whole run is about 21 us; nearly five times that means a hang
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    dbit = 1'b0;
    dstb = 1'b0;
    hsel = 4'h0;
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
    check("oe", {6'h00, scoe, sdoe}, 8'h00);
    check("nib", {cfg, diag}, 8'h00);
    wr(CMD_CFG, 4'hA);
    wr(CMD_MAXHEAD, 4'h3);
    wr(CMD_DIAG, 4'h5);
    wr(4'hF, 4'h1);
    check("cfg", {cfg, maxh}, 8'hA3);
    check("diag", {4'h0, diag}, 8'h05);
    wr(CMD_HEAD_PTR, 4'h0);
    for (int h = 0; h < 4; h++) wr(CMD_SLIM, 4'(h + 9));
    for (int h = 0; h < 4; h++) begin
      @(negedge mclk) hsel = 4'(h);
      @(negedge mclk);
      check("slim", {4'h0, slim}, 8'(h + 9));
    end
    wr(CMD_HEAD_PTR, 4'h6);
    wr(CMD_SLIM, 4'h7);
    @(negedge mclk) hsel = 4'h6;
    @(negedge mclk);
    check("slim6", {4'h0, slim}, 8'h07);
    foreach (st_arg[i]) begin
      wr(CMD_STATUS, st_arg[i]);
      u_proc_port_model.get_byte(got);
      check("status", got, st_exp[i]);
    end
    wr(CMD_READOUT, 4'h0);
    fork
      begin
        feed_sync();
        foreach (rd_val[i]) feed_byte(rd_val[i], rd_ones[i]);
      end
      foreach (rd_val[i]) begin
        u_proc_port_model.get_byte(got);
        check("disk", got, rd_ones[i] > 12 ? rd_val[i] : 8'h00);
        if (i == 1) check("addr_up", {7'h00, got[7:4] > prev[7:4]}, 8'h01);
        prev = got;
      end
    join
    wr(CMD_READOUT, 4'h0);
    feed_sync();
    feed_byte(8'h33, 24);
    repeat (4) @(negedge mclk);
    check("ready", {7'h00, scoe}, 8'h01);
    u_proc_port_model.abort();
    @(negedge mclk);
    check("abort", {6'h00, scoe, sdoe}, 8'h00);
    feed_byte(8'h44, 24);
    check("idle", {7'h00, scoe}, 8'h00);
    check("kept", {cfg, diag}, 8'hA5);
    report_and_stop();
  end
endmodule
bind adaptive_slimming_serial_logic slim_link_asserts #(.HSEL_W(HSEL_W)) u_slim_link_asserts (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .disk_bit_in(disk_bit_in),
  .disk_strobe_in(disk_strobe_in), .head_sel_in(head_sel_in), .ser_clk_in(ser_clk_in),
  .ser_data_in(ser_data_in), .ser_data_out(ser_data_out), .ser_data_oe_out(ser_data_oe_out),
  .ser_ctrl_in(ser_ctrl_in), .ser_ctrl_out(ser_ctrl_out), .ser_ctrl_oe_out(ser_ctrl_oe_out),
  .slim_out(slim_out), .cfg_out(cfg_out), .max_head_out(max_head_out), .diag_out(diag_out));
